// >>> rtl/tmr_pkg.sv
// package: register map, field positions and carrier types for the up-count timer
package tmr_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_A   = 8'h00;
   localparam logic [7:0] OFS_CTRL_B   = 8'h04;
   localparam logic [7:0] OFS_IRQ_DMA  = 8'h0c;
   localparam logic [7:0] OFS_FLAGS    = 8'h10;
   localparam logic [7:0] OFS_SW_EVENT = 8'h14;
   localparam logic [7:0] OFS_COUNT    = 8'h24;
   localparam logic [7:0] OFS_PRESCALE = 8'h28;
   localparam logic [7:0] OFS_RELOAD   = 8'h2c;
   // debug-freeze control, placed in a free slot of the map
   localparam logic [7:0] OFS_DBG_CTRL = 8'h30;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_CEN       = 0;
   localparam int BIT_UPD_INH   = 1;
   localparam int BIT_UPD_SRC   = 2;
   localparam int BIT_ONE_SHOT  = 3;
   localparam int BIT_RLD_SHD   = 7;
   localparam int BIT_MMS_LO    = 4;
   localparam int BIT_IRQ_EN    = 0;
   localparam int BIT_DMA_EN    = 8;
   localparam int BIT_UPD_FLAG  = 0;
   localparam int BIT_SOFT_UPD  = 0;
   localparam int BIT_DBG_FRZ   = 0;

   // ------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [2:0]  MMS_RESET  = 3'h0;
   localparam logic [2:0]  MMS_ENABLE = 3'h1;
   localparam logic [2:0]  MMS_UPDATE = 3'h2;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        en;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } reg_wr_t;

   typedef struct packed {
      logic        count_enable_bit;
      logic        upd_inh;
      logic        upd_src;
      logic        one_shot;
      logic        rld_shd;
      logic [2:0]  mms;
      logic        irq_en;
      logic        dma_en;
      logic        dbg_frz;
   } ctrl_t;
endpackage : tmr_pkg

// >>> rtl/axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight, register access strobes
`timescale 1ns/1ns
`default_nettype none
module axil_slave
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // write address and data
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // write response
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // read address and data
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // register side
   output reg_wr_t          o_wr,
   output logic [7:0]       o_rd_addr,
   input  wire logic [31:0] i_rd_data,
   input  wire logic        i_rd_hit,
   input  wire logic        i_wr_hit
);
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } st_t;

   st_t st_r;
   st_t st_nxt;
   logic do_wr;
   logic do_rd;

   assign o_awready = !st_r.aw_got && !st_r.bvalid;
   assign o_wready  = !st_r.w_got && !st_r.bvalid;
   assign o_arready = !st_r.rvalid;
   assign do_wr     = st_r.aw_got && st_r.w_got;
   assign do_rd     = i_arvalid && o_arready;

   // write strobe is raised in the same cycle that both halves are held
   assign o_wr.en   = do_wr;
   assign o_wr.addr = st_r.aw_addr;
   assign o_wr.data = st_r.w_data;
   assign o_wr.strb = st_r.w_strb;
   assign o_rd_addr = i_araddr;

   always_comb begin
      st_nxt = st_r;
      if (i_awvalid && o_awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = i_wdata;
         st_nxt.w_strb = i_wstrb;
      end
      if (do_wr) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = i_wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st_r.bvalid && i_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (do_rd) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = i_rd_data;
         st_nxt.rresp  = i_rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st_r.rvalid && i_rready) begin
         st_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_bvalid = st_r.bvalid;
   assign o_bresp  = st_r.bresp;
   assign o_rvalid = st_r.rvalid;
   assign o_rdata  = st_r.rdata;
   assign o_rresp  = st_r.rresp;
endmodule : axil_slave
`default_nettype wire

// >>> rtl/upcount_timer.sv
// basic 16-bit up-counting timer with prescaler, shadowed reload and AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module upcount_timer
   import tmr_pkg::*;
#(
   parameter int CNT_W = 16
)(
   // clock and reset
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST_N,
   // AXI4-Lite write address
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [7:0]  I_AWADDR,
   // AXI4-Lite write data
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   // AXI4-Lite write response
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   output logic [1:0]       O_BRESP,
   // AXI4-Lite read
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   input  wire logic [7:0]  I_ARADDR,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   // debug halt from the core
   input  wire logic        I_CORE_HALTED,
   // events
   output logic             O_IRQ,
   output logic             O_DMA_REQ,
   output logic             O_TRIGGER_OUT
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      ctrl_t              ctrl;
      logic               upd_flag;
      logic               soft_upd;
      logic [CNT_W-1:0]   cnt;
      logic [CNT_W-1:0]   psc_cnt;
      logic [CNT_W-1:0]   psc_pre;
      logic [CNT_W-1:0]   psc_act;
      logic [CNT_W-1:0]   rld_pre;
      logic [CNT_W-1:0]   rld_act;
      logic [2:0]         halt_sync;
      logic               halted;
      logic               dma_req;
      logic               trig;
   } st_t;

   st_t            st_r;
   st_t            st_nxt;
   reg_wr_t        wr;
   logic [7:0]     rd_addr;
   logic [31:0]    rd_data;
   logic           rd_hit;
   logic           wr_hit;
   logic [15:0]    wval;
   logic           wlo;
   logic           whi;

   axil_slave u_bus (
      .i_clk     (I_CORE_CLK),
      .i_rst_n   (I_RST_N),
      .i_awvalid (I_AWVALID),
      .o_awready (O_AWREADY),
      .i_awaddr  (I_AWADDR),
      .i_wvalid  (I_WVALID),
      .o_wready  (O_WREADY),
      .i_wdata   (I_WDATA),
      .i_wstrb   (I_WSTRB),
      .o_bvalid  (O_BVALID),
      .i_bready  (I_BREADY),
      .o_bresp   (O_BRESP),
      .i_arvalid (I_ARVALID),
      .o_arready (O_ARREADY),
      .i_araddr  (I_ARADDR),
      .o_rvalid  (O_RVALID),
      .i_rready  (I_RREADY),
      .o_rdata   (O_RDATA),
      .o_rresp   (O_RRESP),
      .o_wr      (wr),
      .o_rd_addr (rd_addr),
      .i_rd_data (rd_data),
      .i_rd_hit  (rd_hit),
      .i_wr_hit  (wr_hit)
   );

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         OFS_CTRL_A, OFS_CTRL_B, OFS_IRQ_DMA, OFS_FLAGS, OFS_SW_EVENT,
         OFS_COUNT, OFS_PRESCALE, OFS_RELOAD, OFS_DBG_CTRL: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   assign rd_hit = mapped(rd_addr);
   assign wr_hit = mapped(wr.addr);
   // registers are 16 bits; upper lanes are ignored
   assign wlo    = wr.en && wr_hit && wr.strb[0];
   assign whi    = wr.en && wr_hit && wr.strb[1];

   // merge byte lanes into the current value of the register written
   function automatic logic [15:0] merge(input logic [15:0] old);
      merge = old;
      if (wr.strb[0]) merge[7:0] = wr.data[7:0];
      if (wr.strb[1]) merge[15:8] = wr.data[15:8];
   endfunction : merge

   always_comb begin
      rd_data = '0;
      case (rd_addr)
         OFS_CTRL_A: begin
            rd_data[BIT_CEN]      = st_r.ctrl.count_enable_bit;
            rd_data[BIT_UPD_INH]  = st_r.ctrl.upd_inh;
            rd_data[BIT_UPD_SRC]  = st_r.ctrl.upd_src;
            rd_data[BIT_ONE_SHOT] = st_r.ctrl.one_shot;
            rd_data[BIT_RLD_SHD]  = st_r.ctrl.rld_shd;
         end
         OFS_CTRL_B:   rd_data[BIT_MMS_LO+:3] = st_r.ctrl.mms;
         OFS_IRQ_DMA: begin
            rd_data[BIT_IRQ_EN] = st_r.ctrl.irq_en;
            rd_data[BIT_DMA_EN] = st_r.ctrl.dma_en;
         end
         OFS_FLAGS:    rd_data[BIT_UPD_FLAG] = st_r.upd_flag;
         OFS_SW_EVENT: rd_data[BIT_SOFT_UPD] = st_r.soft_upd;
         OFS_COUNT:    rd_data[15:0] = st_r.cnt;
         OFS_PRESCALE: rd_data[15:0] = st_r.psc_pre;
         OFS_RELOAD:   rd_data[15:0] = st_r.rld_pre;
         OFS_DBG_CTRL: rd_data[BIT_DBG_FRZ] = st_r.ctrl.dbg_frz;
         default:      rd_data = '0;
      endcase
   end

   // ------------------------------------------------------------
   // counter core
   // ------------------------------------------------------------
   logic frozen;
   logic run;
   logic tick;
   logic ovf;
   logic sw_evt;
   logic upd;
   logic qual;

   always_comb begin
      st_nxt = st_r;
      wval   = merge(16'h0000);

      // halt level from the core is off-domain: three stages, act when last two agree
      st_nxt.halt_sync = {st_r.halt_sync[1:0], I_CORE_HALTED};
      if (st_r.halt_sync[2] == st_r.halt_sync[1]) begin
         st_nxt.halted = st_r.halt_sync[2];
      end

      frozen = st_r.halted && st_r.ctrl.dbg_frz;
      run    = st_r.ctrl.count_enable_bit && !frozen;
      tick   = run && (st_r.psc_cnt == st_r.psc_act);
      ovf    = tick && (st_r.cnt == st_r.rld_act);
      sw_evt = st_r.soft_upd;
      upd    = (ovf || sw_evt) && !st_r.ctrl.upd_inh;
      qual   = upd && (!st_r.ctrl.upd_src || ovf);

      if (run) begin
         st_nxt.psc_cnt = tick ? '0 : st_r.psc_cnt + 1'b1;
      end
      if (tick) begin
         st_nxt.cnt = ovf ? '0 : st_r.cnt + 1'b1;
      end
      if (sw_evt) begin
         st_nxt.cnt      = '0;
         st_nxt.psc_cnt  = '0;
         st_nxt.soft_upd = 1'b0;
      end
      if (upd) begin
         st_nxt.psc_act = st_r.psc_pre;
         st_nxt.rld_act = st_r.rld_pre;
         if (st_r.ctrl.one_shot) begin
            st_nxt.ctrl.count_enable_bit = 1'b0;
         end
      end
      st_nxt.dma_req = qual && st_r.ctrl.dma_en;

      // trigger output select; reset and update pulses last one clock, enable mode follows the enable bit
      case (st_r.ctrl.mms)
         MMS_RESET:  st_nxt.trig = sw_evt;
         MMS_ENABLE: st_nxt.trig = st_r.ctrl.count_enable_bit;
         MMS_UPDATE: st_nxt.trig = upd;
         default:    st_nxt.trig = 1'b0;
      endcase

      // ---------------------------------------------------------
      // register writes
      // ---------------------------------------------------------
      if (wlo || whi) begin
         case (wr.addr)
            OFS_CTRL_A: begin
               if (wlo) begin
                  st_nxt.ctrl.count_enable_bit      = wr.data[BIT_CEN];
                  st_nxt.ctrl.upd_inh  = wr.data[BIT_UPD_INH];
                  st_nxt.ctrl.upd_src  = wr.data[BIT_UPD_SRC];
                  st_nxt.ctrl.one_shot = wr.data[BIT_ONE_SHOT];
                  st_nxt.ctrl.rld_shd  = wr.data[BIT_RLD_SHD];
               end
            end
            OFS_CTRL_B: begin
               if (wlo) st_nxt.ctrl.mms = wr.data[BIT_MMS_LO+:3];
            end
            OFS_IRQ_DMA: begin
               if (wlo) st_nxt.ctrl.irq_en = wr.data[BIT_IRQ_EN];
               if (whi) st_nxt.ctrl.dma_en = wr.data[BIT_DMA_EN];
            end
            OFS_FLAGS: begin
               // writing 0 clears; a same-cycle set is applied below and wins
               if (wlo && !wr.data[BIT_UPD_FLAG]) st_nxt.upd_flag = 1'b0;
            end
            OFS_SW_EVENT: begin
               if (wlo && wr.data[BIT_SOFT_UPD]) st_nxt.soft_upd = 1'b1;
            end
            OFS_COUNT: begin
               wval       = merge(st_r.cnt);
               st_nxt.cnt = wval;
            end
            OFS_PRESCALE: begin
               wval           = merge(st_r.psc_pre);
               st_nxt.psc_pre = wval;
            end
            OFS_RELOAD: begin
               wval           = merge(st_r.rld_pre);
               st_nxt.rld_pre = wval;
               if (!st_r.ctrl.rld_shd) begin
                  st_nxt.rld_act = wval;
               end
            end
            OFS_DBG_CTRL: begin
               if (wlo) st_nxt.ctrl.dbg_frz = wr.data[BIT_DBG_FRZ];
            end
            default: begin
               st_nxt.cnt = st_nxt.cnt;
            end
         endcase
      end
      if (qual) begin
         st_nxt.upd_flag = 1'b1;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign O_IRQ         = st_r.upd_flag && st_r.ctrl.irq_en;
   assign O_DMA_REQ     = st_r.dma_req;
   assign O_TRIGGER_OUT = st_r.trig;
endmodule : upcount_timer
`default_nettype wire

// >>> test/upcount_timer_chk.sv
// port-level assertions for the up-count timer
`timescale 1ns/1ns
`default_nettype none
module upcount_timer_chk
   import tmr_pkg::*;
(
   // clock, reset and register bus
   input wire logic        I_CORE_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic        I_WVALID,
   input wire logic        O_WREADY,
   input wire logic        O_BVALID,
   input wire logic        I_BREADY,
   input wire logic        I_ARVALID,
   input wire logic        O_ARREADY,
   input wire logic [7:0]  I_ARADDR,
   input wire logic        O_RVALID,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0]  O_RRESP,
   // events
   input wire logic        O_IRQ,
   input wire logic        O_DMA_REQ,
   input wire logic        O_TRIGGER_OUT
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   property p_rst_idle;
      $rose(I_RST_N) |-> !(O_BVALID || O_RVALID || O_IRQ || O_DMA_REQ || O_TRIGGER_OUT);
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("outputs active after reset");

   property p_wr_resp;
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID;
   endproperty
   a_wr_resp: assert property (p_wr_resp)
      else $error("write response late");

   property p_rd_resp;
      I_ARVALID && O_ARREADY |=> O_RVALID;
   endproperty
   a_rd_resp: assert property (p_rd_resp)
      else $error("read answer late");

   property p_unmapped;
      I_ARVALID && O_ARREADY && I_ARADDR == 8'h08 |=> O_RRESP == RESP_SLVERR && O_RDATA == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");

   property p_b_refuse;
      O_BVALID |-> !O_AWREADY && !O_WREADY;
   endproperty
   a_b_refuse: assert property (p_b_refuse)
      else $error("write taken while response pending");

   property p_r_refuse;
      O_RVALID |-> !O_ARREADY;
   endproperty
   a_r_refuse: assert property (p_r_refuse)
      else $error("read taken while answer pending");

   property p_b_release;
      O_BVALID && I_BREADY |=> !O_BVALID;
   endproperty
   a_b_release: assert property (p_b_release)
      else $error("write response not released");

   // the flag only falls through a register write
   property p_irq_hold;
      O_IRQ |=> O_IRQ || $rose(O_BVALID);
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped without a write");
endmodule : upcount_timer_chk

bind upcount_timer upcount_timer_chk u_chk (.*);
`default_nettype wire

// >>> test/upcount_timer_bench.sv
// self-checking bench for the up-count timer over its register bus
`timescale 1ns/1ns
`default_nettype none
module upcount_timer_bench
   import tmr_pkg::*;
;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, halted;
   logic        awready, wready, bvalid, arready, rvalid, irq, dma, trig;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, o_rdata, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, o_bresp, o_rresp;
   int          miscompares = 0, n_compared = 0, ntrig = 0, p, c0, k;
   logic [7:0]  ofs [9] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_IRQ_DMA, OFS_FLAGS, OFS_SW_EVENT,
                         OFS_COUNT, OFS_PRESCALE, OFS_RELOAD, OFS_DBG_CTRL};

   upcount_timer uut (
      .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
      .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(o_bresp),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
      .I_RREADY(rready), .O_RDATA(o_rdata), .O_RRESP(o_rresp), .I_CORE_HALTED(halted),
      .O_IRQ(irq), .O_DMA_REQ(dma), .O_TRIGGER_OUT(trig)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // high cycles of the trigger, so a wide pulse counts more than once
   always @(posedge clk) begin
      if (trig === 1'b1) ntrig <= ntrig + 1;
   end

   // ---------------------------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic guard(input bit bad);
      if (bad) begin
         miscompares++;
         stop_test();
      end
   endtask : guard

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      int   n;
      logic aw, w, ta, tw, bv;
      n  = 0;
      aw = 1'b1;
      w  = 1'b1;
      bv = 1'b0;
      @(posedge clk);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      while ((aw || w) && n < 64) begin
         @(negedge clk);
         ta = aw && awready;
         tw = w && wready;
         @(posedge clk);
         n++;
         if (ta) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (tw) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (bv !== 1'b1 && n < 64) begin
         @(negedge clk);
         bv    = bvalid;
         bresp = o_bresp;
         @(posedge clk);
         n++;
      end
      bready <= 1'b0;
      guard(n >= 64);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int   n;
      logic rv;
      n = 0;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do begin
         @(negedge clk);
         rv = arready;
         @(posedge clk);
         n++;
      end while (rv !== 1'b1 && n < 64);
      arvalid <= 1'b0;
      rv = 1'b0;
      while (rv !== 1'b1 && n < 64) begin
         @(negedge clk);
         rv    = rvalid;
         rdata = o_rdata;
         rresp = o_rresp;
         @(posedge clk);
         n++;
      end
      rready <= 1'b0;
      guard(n >= 64);
   endtask : rd

   // cycles between two rising edges of the trigger (sel 0) or dma request (sel 1)
   task automatic per(input bit sel, output int cyc);
      int   n, hits;
      logic s, q;
      q    = 1'b1;
      hits = 0;
      cyc  = 0;
      for (n = 0; n < 400 && hits < 2; n++) begin
         @(negedge clk);
         s = sel ? dma : trig;
         if (s === 1'b1 && q !== 1'b1) hits++;
         if (hits == 1) cyc++;
         q = s;
      end
      guard(hits < 2);
   endtask : per

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n   = 1'b0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      halted  = 1'b0;
      awaddr  = 8'h00;
      araddr  = 8'h00;
      wdata   = 32'h0;
      wstrb   = 4'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ofs[i]) begin
         rd(ofs[i]);
         chk(rdata, 32'h0);
      end
      rd(8'h08);
      chk(rresp, RESP_SLVERR);
      wr(8'h08, 32'h1);
      chk(bresp, RESP_SLVERR);
      wr(OFS_COUNT, 32'h1234, 4'h3);
      wr(OFS_COUNT, 32'hffff_0000, 4'hc);
      rd(OFS_COUNT);
      chk(rdata, 32'h1234);
      wr(OFS_CTRL_B, 32'h20);
      wr(OFS_RELOAD, 32'h4);
      wr(OFS_PRESCALE, 32'h2);
      wr(OFS_SW_EVENT, 32'h1);
      wr(OFS_CTRL_A, 32'h1);
      per(1'b0, p);
      chk(p, 15);
      wr(OFS_PRESCALE, 32'h0);
      wr(OFS_IRQ_DMA, 32'h100);
      per(1'b1, p);
      chk(p, 5);
      wr(OFS_CTRL_A, 32'h81);
      wr(OFS_RELOAD, 32'h9);
      per(1'b0, p);
      chk(p, 10);
      wr(OFS_IRQ_DMA, 32'h101);
      @(negedge clk);
      chk(irq, 1'b1);
      wr(OFS_CTRL_A, 32'h0);
      rd(OFS_COUNT);
      v = rdata;
      rd(OFS_COUNT);
      chk(rdata, v);
      wr(OFS_FLAGS, 32'h1);
      rd(OFS_FLAGS);
      chk(rdata, 32'h1);
      wr(OFS_FLAGS, 32'h0);
      rd(OFS_FLAGS);
      chk(rdata, 32'h0);
      chk(irq, 1'b0);
      wr(OFS_CTRL_A, 32'h4);
      wr(OFS_SW_EVENT, 32'h1);
      rd(OFS_FLAGS);
      chk(rdata, 32'h0);
      rd(OFS_COUNT);
      chk(rdata, 32'h0);
      rd(OFS_SW_EVENT);
      chk(rdata, 32'h0);
      wr(OFS_CTRL_A, 32'h2);
      wr(OFS_COUNT, 32'h55);
      wr(OFS_SW_EVENT, 32'h1);
      rd(OFS_COUNT);
      chk(rdata, 32'h0);
      rd(OFS_FLAGS);
      chk(rdata, 32'h0);
      wr(OFS_CTRL_A, 32'h9);
      k = 0;
      do begin
         rd(OFS_CTRL_A);
         k++;
      end while (rdata !== 32'h8 && k < 20);
      chk(rdata, 32'h8);
      rd(OFS_COUNT);
      chk(rdata, 32'h0);
      wr(OFS_CTRL_B, 32'h10);
      chk(trig, 1'b0);
      wr(OFS_CTRL_A, 32'h1);
      @(negedge clk);
      chk(trig, 1'b1);
      wr(OFS_CTRL_B, 32'h0);
      // let the last enable-mode high cycle land in the count before taking the base
      @(negedge clk);
      c0 = ntrig;
      wr(OFS_SW_EVENT, 32'h1);
      repeat (4) @(negedge clk);
      chk(ntrig - c0, 1);
      wr(OFS_RELOAD, 32'hffff);
      wr(OFS_DBG_CTRL, 32'h1);
      @(posedge clk);
      halted <= 1'b1;
      repeat (6) @(posedge clk);
      rd(OFS_COUNT);
      v = rdata;
      rd(OFS_COUNT);
      chk(rdata, v);
      halted <= 1'b0;
      repeat (6) @(posedge clk);
      rd(OFS_COUNT);
      chk(rdata > v, 1'b1);
      stop_test();
   end
endmodule : upcount_timer_bench
`default_nettype wire
